// ===== core/pin_mux_regs.svh
/*
 Pin positions and reset values for the port D/E override block.
 Assumes a 16-bit pin vector: port D in bits 7..0, port E in bits 15..8.
*/
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ************************************
// port D pins
// ************************************
`define PIN_CNT0 7
`define PIN_CNT1 6
`define PIN_XCK 5
`define PIN_CAP 4
`define PIN_TX 3
`define PIN_RX 2
`define PIN_SDA 1
`define PIN_SCL 0

// ************************************
// port E pins
// ************************************
`define PIN_SUPPLY 15
`define PIN_OSC_OUT 13
`define PIN_OSC_IN 12
`define PIN_USB_ID 11
`define PIN_ALE 10
`define PIN_RD 9
`define PIN_WR 8

// ************************************
// reset values
// ************************************
`define BOOT_RESET 1'h0
`define PAD_RESET 16'h0000

`endif

// ===== core/pin_mux_pkg.sv
/*
 Types for the port D/E override block.
 Assumes nothing beyond the pin layout of pin_mux_regs.svh.
*/
package pin_mux_pkg;
    // whole registered state of the block
    typedef struct packed {
        logic [15:0] pu;
        logic [15:0] dir;
        logic [15:0] val;
        logic [15:0] ie;
        logic [7:0] irq;
        logic cnt0;
        logic cnt1;
        logic xck_in;
        logic capture;
        logic rx;
        logic sda_in;
        logic scl_in;
        logic usb_id;
        logic boot;
    } pin_state_t;
endpackage

// ===== core/port_d_e_alt_function_override.sv
/*
 Override logic for two eight-bit ports (D in bits 7..0, E in 15..8):
 port-register defaults, peripheral override enables/values, final pad
 controls and routed digital inputs, all registered one cycle.
 Assumes all inputs synchronous to CLOCK; pads and analog parts outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.svh"

module port_d_e_alt_function_override (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [15:0] PORT_DIR,
    input wire logic [15:0] PORT_OUT,
    input wire logic [15:0] PIN_IN,
    input wire logic GLOBAL_PULLUP_DISABLE,
    input wire logic SLEEP_INPUT_OFF,
    input wire logic SERIAL_SYNC_MODE,
    input wire logic XCK_OUT,
    input wire logic SERIAL_TX_ON,
    input wire logic TX_DATA,
    input wire logic SERIAL_RX_ON,
    input wire logic TWO_WIRE_ON,
    input wire logic SDA_DRIVE_LOW,
    input wire logic SCL_DRIVE_LOW,
    input wire logic COMPARE2_B_ON,
    input wire logic TIMER2_COMPARE_B_OUT,
    input wire logic COMPARE0_B_ON,
    input wire logic TIMER0_COMPARE_B_OUT,
    input wire logic [7:0] IRQ_ENABLE,
    input wire logic ASYNC_CLOCK_SELECT_BIT,
    input wire logic BUS_SUPPLY_CONTROL_ON,
    input wire logic BUS_SUPPLY_CONTROL,
    input wire logic USB_ID_PIN_ON,
    input wire logic EXT_MEM_ON,
    input wire logic ALE_STROBE,
    input wire logic RD_STROBE,
    input wire logic WR_STROBE,
    input wire logic BOOT_SELECT_FUSE,
    input wire logic EXT_RESET_ACTIVE,
    output logic [15:0] PAD_PULLUP,
    output logic [15:0] PAD_DIR,
    output logic [15:0] PAD_OUT,
    output logic [15:0] PAD_IN_EN,
    output logic [7:0] EXT_IRQ_IN,
    output logic COUNTER0_EXT_CLOCK_IN,
    output logic COUNTER1_EXT_CLOCK_IN,
    output logic XCK_IN,
    output logic TIMER_CAPTURE_IN,
    output logic RX_DATA,
    output logic SDA_IN,
    output logic SCL_IN,
    output logic USB_ID_IN,
    output logic BOOT_TO_LOADER
);

    // ************************************
    // override table
    // ************************************
    logic [15:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, ie_oe, ie_ov;
    logic [15:0] pu_reg, ie_reg, fin_pu, fin_dir, fin_val, fin_ie;
    logic xck_drive;
    pin_mux_pkg::pin_state_t s_q, s_d;

    // clock pin only drives in synchronous mode
    assign xck_drive = SERIAL_SYNC_MODE & PORT_DIR[`PIN_XCK];

    // enables and values per pin; osc block placed last so it wins
    always_comb
    begin
        pu_oe = '0;
        pu_ov = '0;
        dd_oe = '0;
        dd_ov = '0;
        pv_oe = '0;
        pv_ov = '0;
        ie_oe = '0;
        ie_ov = '0;
        // upper D: only the serial clock overrides anything
        dd_oe[`PIN_XCK] = xck_drive;
        dd_ov[`PIN_XCK] = 1'h1;
        pv_oe[`PIN_XCK] = xck_drive;
        pv_ov[`PIN_XCK] = XCK_OUT;
        // transmit pin
        pu_oe[`PIN_TX] = SERIAL_TX_ON;
        dd_oe[`PIN_TX] = SERIAL_TX_ON;
        dd_ov[`PIN_TX] = 1'h1;
        pv_oe[`PIN_TX] = SERIAL_TX_ON;
        pv_ov[`PIN_TX] = TX_DATA;
        // receive pin, pull-up still under software
        pu_oe[`PIN_RX] = SERIAL_RX_ON;
        pu_ov[`PIN_RX] = PORT_OUT[`PIN_RX] & ~GLOBAL_PULLUP_DISABLE;
        dd_oe[`PIN_RX] = SERIAL_RX_ON;
        // open drain: value held low while two-wire owns the pin
        pu_oe[`PIN_SDA] = TWO_WIRE_ON;
        pu_ov[`PIN_SDA] = PORT_OUT[`PIN_SDA] & ~GLOBAL_PULLUP_DISABLE;
        dd_oe[`PIN_SDA] = TWO_WIRE_ON;
        dd_ov[`PIN_SDA] = SDA_DRIVE_LOW;
        pv_oe[`PIN_SDA] = TWO_WIRE_ON | COMPARE2_B_ON;
        pv_ov[`PIN_SDA] = TIMER2_COMPARE_B_OUT & ~TWO_WIRE_ON;
        pu_oe[`PIN_SCL] = TWO_WIRE_ON;
        pu_ov[`PIN_SCL] = PORT_OUT[`PIN_SCL] & ~GLOBAL_PULLUP_DISABLE;
        dd_oe[`PIN_SCL] = TWO_WIRE_ON;
        dd_ov[`PIN_SCL] = SCL_DRIVE_LOW;
        pv_oe[`PIN_SCL] = TWO_WIRE_ON | COMPARE0_B_ON;
        pv_ov[`PIN_SCL] = TIMER0_COMPARE_B_OUT & ~TWO_WIRE_ON;
        // interrupt lines keep their input buffers awake
        ie_oe[3:0] = IRQ_ENABLE[3:0];
        ie_ov[3:0] = 4'hF;
        ie_oe[15:12] = IRQ_ENABLE[7:4];
        ie_ov[15:12] = 4'hF;
        // supply control
        dd_oe[`PIN_SUPPLY] = BUS_SUPPLY_CONTROL_ON;
        dd_ov[`PIN_SUPPLY] = 1'h1;
        pv_oe[`PIN_SUPPLY] = BUS_SUPPLY_CONTROL_ON;
        pv_ov[`PIN_SUPPLY] = BUS_SUPPLY_CONTROL;
        // id pin: input with pull-up
        pu_oe[`PIN_USB_ID] = USB_ID_PIN_ON;
        pu_ov[`PIN_USB_ID] = 1'h1;
        dd_oe[`PIN_USB_ID] = USB_ID_PIN_ON;
        ie_oe[`PIN_USB_ID] = USB_ID_PIN_ON;
        ie_ov[`PIN_USB_ID] = 1'h1;
        // external memory strobes
        pu_oe[10:8] = {3{EXT_MEM_ON}};
        dd_oe[10:8] = {3{EXT_MEM_ON}};
        dd_ov[10:8] = 3'h6;
        pv_oe[10:8] = {3{EXT_MEM_ON}};
        pv_ov[10:8] = {ALE_STROBE, RD_STROBE, WR_STROBE};
        // crystal pins: nothing digital may touch them
        if (ASYNC_CLOCK_SELECT_BIT)
        begin
            pu_oe[13:12] = 2'h3;
            pu_ov[13:12] = 2'h0;
            dd_oe[13:12] = 2'h3;
            dd_ov[13:12] = 2'h0;
            pv_oe[13:12] = 2'h3;
            pv_ov[13:12] = 2'h0;
            ie_oe[13:12] = 2'h3;
            ie_ov[13:12] = 2'h0;
        end
    end

    // ************************************
    // final selection per pin
    // ************************************
    // software defaults: pull-up only on inputs, buffer off in sleep
    assign pu_reg = PORT_OUT & ~PORT_DIR & {16{~GLOBAL_PULLUP_DISABLE}};
    assign ie_reg = {16{~SLEEP_INPUT_OFF}};

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_pin
            assign fin_pu[gi] = pu_oe[gi] ? pu_ov[gi] : pu_reg[gi];
            assign fin_dir[gi] = dd_oe[gi] ? dd_ov[gi] : PORT_DIR[gi];
            assign fin_val[gi] = pv_oe[gi] ? pv_ov[gi] : PORT_OUT[gi];
            assign fin_ie[gi] = ie_oe[gi] ? ie_ov[gi] : ie_reg[gi];
        end
    endgenerate

    // ************************************
    // state update
    // ************************************
    // next state; inputs gated by the final buffer enable, except SDA and SCL, gated by TWO_WIRE_ON only, and the boot strap pin, not gated
    always_comb
    begin
        s_d = s_q;
        s_d.pu = fin_pu;
        s_d.dir = fin_dir;
        s_d.val = fin_val;
        s_d.ie = fin_ie;
        s_d.irq = {PIN_IN[15:12] & fin_ie[15:12], PIN_IN[3:0] & fin_ie[3:0]};
        s_d.cnt0 = PIN_IN[`PIN_CNT0] & fin_ie[`PIN_CNT0];
        s_d.cnt1 = PIN_IN[`PIN_CNT1] & fin_ie[`PIN_CNT1];
        s_d.xck_in = PIN_IN[`PIN_XCK] & fin_ie[`PIN_XCK] & SERIAL_SYNC_MODE & ~PORT_DIR[`PIN_XCK];
        s_d.capture = PIN_IN[`PIN_CAP] & fin_ie[`PIN_CAP];
        s_d.rx = PIN_IN[`PIN_RX] & fin_ie[`PIN_RX] & SERIAL_RX_ON;
        s_d.sda_in = PIN_IN[`PIN_SDA] & TWO_WIRE_ON;
        s_d.scl_in = PIN_IN[`PIN_SCL] & TWO_WIRE_ON;
        s_d.usb_id = PIN_IN[`PIN_USB_ID] & fin_ie[`PIN_USB_ID];
        // strap follows the pin for as long as the external reset lasts
        if (EXT_RESET_ACTIVE)
        begin
            s_d.boot = BOOT_SELECT_FUSE & ~PIN_IN[`PIN_ALE];
        end
    end

    // single register for the whole state
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs come straight from the state register
    assign PAD_PULLUP = s_q.pu;
    assign PAD_DIR = s_q.dir;
    assign PAD_OUT = s_q.val;
    assign PAD_IN_EN = s_q.ie;
    assign EXT_IRQ_IN = s_q.irq;
    assign COUNTER0_EXT_CLOCK_IN = s_q.cnt0;
    assign COUNTER1_EXT_CLOCK_IN = s_q.cnt1;
    assign XCK_IN = s_q.xck_in;
    assign TIMER_CAPTURE_IN = s_q.capture;
    assign RX_DATA = s_q.rx;
    assign SDA_IN = s_q.sda_in;
    assign SCL_IN = s_q.scl_in;
    assign USB_ID_IN = s_q.usb_id;
    assign BOOT_TO_LOADER = s_q.boot;

    // ************************************
    // checks
    // ************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    property p_xck;
        SERIAL_SYNC_MODE && PORT_DIR[5] |=> PAD_DIR[5] && PAD_OUT[5] == $past(XCK_OUT);
    endproperty
    a_xck: assert property (p_xck) else $error("clock pin not driven");

    property p_tx;
        SERIAL_TX_ON |=> PAD_DIR[3] && !PAD_PULLUP[3] && PAD_OUT[3] == $past(TX_DATA);
    endproperty
    a_tx: assert property (p_tx) else $error("tx pin not forced out");

    property p_rx;
        SERIAL_RX_ON |=> !PAD_DIR[2] && PAD_PULLUP[2] == $past(PORT_OUT[2] && !GLOBAL_PULLUP_DISABLE);
    endproperty
    a_rx: assert property (p_rx) else $error("rx pin not forced in");

    property p_sda;
        TWO_WIRE_ON ##1 TWO_WIRE_ON |-> PAD_DIR[1] == $past(SDA_DRIVE_LOW) && !PAD_OUT[1];
    endproperty
    a_sda: assert property (p_sda) else $error("data line not open drain");

    property p_scl;
        TWO_WIRE_ON |=> PAD_DIR[0] == $past(SCL_DRIVE_LOW) && !PAD_OUT[0];
    endproperty
    a_scl: assert property (p_scl) else $error("clock line not open drain");

    property p_oc;
        !TWO_WIRE_ON && COMPARE2_B_ON |=> PAD_OUT[1] == $past(TIMER2_COMPARE_B_OUT);
    endproperty
    a_oc: assert property (p_oc) else $error("compare value lost");

    property p_irq_ie;
        IRQ_ENABLE[0] && SLEEP_INPUT_OFF |=> PAD_IN_EN[0];
    endproperty
    a_irq_ie: assert property (p_irq_ie) else $error("irq buffer disabled");

    property p_cap;
        1'h1 |=> PAD_DIR[4] == $past(PORT_DIR[4]) && TIMER_CAPTURE_IN == $past(PIN_IN[4] && !SLEEP_INPUT_OFF);
    endproperty
    a_cap: assert property (p_cap) else $error("capture pin altered");

    property p_osc;
        ASYNC_CLOCK_SELECT_BIT |=> !PAD_IN_EN[12] && !PAD_DIR[13] && !PAD_PULLUP[12] && !EXT_IRQ_IN[4];
    endproperty
    a_osc: assert property (p_osc) else $error("osc pin still in use");

    property p_supply;
        BUS_SUPPLY_CONTROL_ON |=> PAD_DIR[15] && PAD_OUT[15] == $past(BUS_SUPPLY_CONTROL);
    endproperty
    a_supply: assert property (p_supply) else $error("supply pin not driven");

    property p_boot;
        EXT_RESET_ACTIVE && BOOT_SELECT_FUSE && !PIN_IN[10] ##1 (!EXT_RESET_ACTIVE) [*3] |-> BOOT_TO_LOADER;
    endproperty
    a_boot: assert property (p_boot) else $error("boot select lost");

    property p_mem;
        EXT_MEM_ON |=> PAD_DIR[10] && PAD_DIR[9] && PAD_OUT[9] == $past(RD_STROBE) && !PAD_PULLUP[8];
    endproperty
    a_mem: assert property (p_mem) else $error("strobe pins not driven");

    property p_plain;
        1'h1 |=> PAD_PULLUP[6] == $past(PORT_OUT[6] && !PORT_DIR[6] && !GLOBAL_PULLUP_DISABLE);
    endproperty
    a_plain: assert property (p_plain) else $error("default pull-up wrong");

endmodule // port_d_e_alt_function_override

`default_nettype wire

// ===== tb/periph_model.sv
/*
 Stand-in for the peripherals that borrow port pins: serial clock,
 transmit data and memory strobes. Assumes the bench raises RUN.
*/
`timescale 1ns/1ps
`default_nettype none

module periph_model (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic RUN,
    output logic XCK_OUT,
    output logic TX_DATA,
    output logic ALE_STROBE,
    output logic RD_STROBE,
    output logic WR_STROBE
);
    // ************
    // phase count
    // ************
    logic [2:0] ph_q;

    // moves just after the edge, like any other requester
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            ph_q <= 3'h0;
        else if (RUN)
            ph_q <= #1 ph_q + 3'h1;
    end

    // clock stands still between frames
    assign XCK_OUT = RUN & ph_q[0];
    assign TX_DATA = ph_q[1] ^ ph_q[2];
    assign ALE_STROBE = ph_q[1:0] == 2'h1;
    assign RD_STROBE = ph_q[1:0] == 2'h2;
    assign WR_STROBE = ph_q[1:0] == 2'h3;
endmodule // periph_model

`default_nettype wire

// ===== tb/port_d_e_alt_function_override_tb.sv
/*
 Self-checking bench for the port D/E override block.
 Assumes outputs follow the inputs of the previous edge.
*/
`timescale 1ns/1ps
`default_nettype none

module port_d_e_alt_function_override_tb;
    logic CLOCK, RST, GLOBAL_PULLUP_DISABLE, SLEEP_INPUT_OFF, SERIAL_SYNC_MODE, XCK_OUT;
    logic SERIAL_TX_ON, TX_DATA, SERIAL_RX_ON, TWO_WIRE_ON, SDA_DRIVE_LOW, SCL_DRIVE_LOW;
    logic COMPARE2_B_ON, TIMER2_COMPARE_B_OUT, COMPARE0_B_ON, TIMER0_COMPARE_B_OUT, ASYNC_CLOCK_SELECT_BIT;
    logic BUS_SUPPLY_CONTROL_ON, BUS_SUPPLY_CONTROL, USB_ID_PIN_ON, EXT_MEM_ON, ALE_STROBE;
    logic RD_STROBE, WR_STROBE, BOOT_SELECT_FUSE, EXT_RESET_ACTIVE, COUNTER0_EXT_CLOCK_IN;
    logic COUNTER1_EXT_CLOCK_IN, XCK_IN, TIMER_CAPTURE_IN, RX_DATA, SDA_IN, SCL_IN, USB_ID_IN;
    logic BOOT_TO_LOADER, run, xck_s, tx_s;
    logic [15:0] PORT_DIR, PORT_OUT, PIN_IN, PAD_PULLUP, PAD_DIR, PAD_OUT, PAD_IN_EN;
    logic [7:0] IRQ_ENABLE, EXT_IRQ_IN;
    logic [2:0] stb_s;
    int err_total, n_compared;

    port_d_e_alt_function_override DUT (.*);
    periph_model PARTNER (.CLOCK(CLOCK), .RST(RST), .RUN(run), .XCK_OUT(XCK_OUT), .TX_DATA(TX_DATA),
        .ALE_STROBE(ALE_STROBE), .RD_STROBE(RD_STROBE), .WR_STROBE(WR_STROBE));

    // ************
    // helpers
    // ************
    // 25 ns clock
    initial
    begin
        CLOCK = 1'h0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    task automatic chk_vec(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        chk_vec({15'h0000, g}, {15'h0000, e});
    endtask

    // partner values are snapshot before the capturing edge
    task automatic step;
        @(negedge CLOCK);
        xck_s = XCK_OUT;
        tx_s = TX_DATA;
        stb_s = {ALE_STROBE, RD_STROBE, WR_STROBE};
        @(posedge CLOCK);
        #1;
    endtask

    task automatic idle;
        {GLOBAL_PULLUP_DISABLE, SLEEP_INPUT_OFF, SERIAL_SYNC_MODE, SERIAL_TX_ON, SERIAL_RX_ON} = '0;
        {TWO_WIRE_ON, SDA_DRIVE_LOW, SCL_DRIVE_LOW, COMPARE2_B_ON, TIMER2_COMPARE_B_OUT, COMPARE0_B_ON} = '0;
        {TIMER0_COMPARE_B_OUT, ASYNC_CLOCK_SELECT_BIT, BUS_SUPPLY_CONTROL_ON, BUS_SUPPLY_CONTROL} = '0;
        {USB_ID_PIN_ON, EXT_MEM_ON, BOOT_SELECT_FUSE, EXT_RESET_ACTIVE, run} = '0;
        {PORT_DIR, PORT_OUT, PIN_IN, IRQ_ENABLE} = '0;
    endtask

    task automatic summarize;
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ************
    // scenarios
    // ************
    task automatic t_default;
        PORT_DIR = 16'h0f0f;
        PORT_OUT = 16'h33cc;
        PIN_IN = 16'ha5f3;
        step();
        chk_vec(PAD_DIR, 16'h0f0f);
        chk_vec(PAD_OUT, 16'h33cc);
        chk_vec(PAD_PULLUP, 16'h30c0);
        chk_vec(PAD_IN_EN, 16'hffff);
        chk_vec({8'h00, EXT_IRQ_IN}, 16'h00a3);
        chk_vec({12'h000, COUNTER0_EXT_CLOCK_IN, COUNTER1_EXT_CLOCK_IN, TIMER_CAPTURE_IN, XCK_IN}, 16'h000e);
        GLOBAL_PULLUP_DISABLE = 1'h1;
        SLEEP_INPUT_OFF = 1'h1;
        step();
        chk_vec(PAD_PULLUP | PAD_IN_EN, 16'h0000);
        idle();
    endtask

    // transmit and receive together, pins set the wrong way round
    task automatic t_serial;
        SERIAL_TX_ON = 1'h1;
        SERIAL_RX_ON = 1'h1;
        PORT_DIR = 16'h0004;
        PORT_OUT = 16'h000c;
        run = 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            PIN_IN[2] = i[0];
            step();
            chk_vec(PAD_DIR & 16'h000c, 16'h0008);
            chk_bit(PAD_OUT[3], tx_s);
            chk_vec(PAD_PULLUP & 16'h000c, 16'h0004);
            chk_bit(RX_DATA, i[0]);
        end
        GLOBAL_PULLUP_DISABLE = 1'h1;
        step();
        chk_bit(PAD_PULLUP[2], 1'h0);
        idle();
    endtask

    task automatic t_xck;
        SERIAL_SYNC_MODE = 1'h1;
        PORT_DIR = 16'h0020;
        run = 1'h1;
        repeat (3)
        begin
            step();
            chk_vec(PAD_DIR & 16'h0020, 16'h0020);
            chk_bit(PAD_OUT[5], xck_s);
        end
        SERIAL_SYNC_MODE = 1'h0;
        PORT_DIR = 16'h0000;
        PIN_IN = 16'h0020;
        step();
        chk_bit(XCK_IN, 1'h0);
        SERIAL_SYNC_MODE = 1'h1;
        step();
        chk_bit(XCK_IN, 1'h1);
        idle();
    endtask

    task automatic t_twi;
        TWO_WIRE_ON = 1'h1;
        PORT_OUT = 16'h0003;
        for (int i = 0; i < 4; i++)
        begin
            {SDA_DRIVE_LOW, SCL_DRIVE_LOW} = i[1:0];
            PORT_DIR = {14'h0000, ~i[1:0]};
            PIN_IN = {14'h0000, ~i[1:0]};
            step();
            chk_vec(PAD_DIR, {14'h0000, i[1:0]});
            chk_vec(PAD_OUT, 16'h0000);
            chk_vec(PAD_PULLUP, 16'h0003);
            chk_vec({14'h0000, SDA_IN, SCL_IN}, PIN_IN);
        end
        TWO_WIRE_ON = 1'h0;
        COMPARE2_B_ON = 1'h1;
        TIMER2_COMPARE_B_OUT = 1'h1;
        TIMER0_COMPARE_B_OUT = 1'h1;
        PORT_OUT = 16'h0000;
        PIN_IN = 16'h0003;
        step();
        chk_vec(PAD_OUT, 16'h0002);
        COMPARE0_B_ON = 1'h1;
        TIMER2_COMPARE_B_OUT = 1'h0;
        step();
        chk_vec(PAD_OUT, 16'h0001);
        chk_bit(SDA_IN, 1'h0);
        chk_bit(SCL_IN, 1'h0);
        idle();
    endtask

    // asleep: only enabled interrupts keep buffers; oscillator wins
    task automatic t_irq;
        SLEEP_INPUT_OFF = 1'h1;
        IRQ_ENABLE = 8'hff;
        PIN_IN = 16'hffff;
        step();
        chk_vec(PAD_IN_EN, 16'hf00f);
        chk_vec({8'h00, EXT_IRQ_IN}, 16'h00ff);
        ASYNC_CLOCK_SELECT_BIT = 1'h1;
        PORT_DIR = 16'h2000;
        PORT_OUT = 16'hffff;
        step();
        chk_vec(PAD_IN_EN, 16'hc00f);
        chk_vec((PAD_DIR | PAD_OUT | PAD_PULLUP) & 16'h3000, 16'h0000);
        chk_vec({8'h00, EXT_IRQ_IN}, 16'h00cf);
        idle();
    endtask

    task automatic t_emem;
        BUS_SUPPLY_CONTROL_ON = 1'h1;
        EXT_MEM_ON = 1'h1;
        USB_ID_PIN_ON = 1'h1;
        SLEEP_INPUT_OFF = 1'h1;
        GLOBAL_PULLUP_DISABLE = 1'h1;
        PORT_DIR = 16'h0900;
        PORT_OUT = 16'h0700;
        run = 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            BUS_SUPPLY_CONTROL = i[0];
            PIN_IN = {4'h0, i[1], 11'h000};
            step();
            chk_vec(PAD_DIR & 16'h8f00, 16'h8600);
            chk_vec(PAD_OUT & 16'h8700, {i[0], 4'h0, stb_s, 8'h00});
            chk_vec(PAD_PULLUP & 16'h0f00, 16'h0800);
            chk_bit(PAD_IN_EN[11], 1'h1);
            chk_bit(USB_ID_IN, i[1]);
        end
        idle();
    endtask

    // fuse, pin level, expected loader start
    task automatic t_boot;
        logic [2:0] tbl [3] = '{3'h5, 3'h0, 3'h6};
        foreach (tbl[k])
        begin
            RST = 1'h1;
            EXT_RESET_ACTIVE = 1'h1;
            BOOT_SELECT_FUSE = tbl[k][2];
            PIN_IN = {5'h00, tbl[k][1], 10'h000};
            step();
            RST = 1'h0;
            step();
            step();
            chk_bit(BOOT_TO_LOADER, tbl[k][0]);
            EXT_RESET_ACTIVE = 1'h0;
            PIN_IN = ~PIN_IN;
            step();
            step();
            step();
            chk_bit(BOOT_TO_LOADER, tbl[k][0]);
        end
        idle();
    endtask

    // ************
    // main sequence
    // ************
    initial
    begin
        err_total = 0;
        n_compared = 0;
        idle();
        RST = 1'h1;
        repeat (2) @(posedge CLOCK);
        #1;
        chk_vec(PAD_DIR | PAD_OUT | PAD_PULLUP | PAD_IN_EN, 16'h0000);
        RST = 1'h0;
        t_default();
        t_serial();
        t_xck();
        t_twi();
        t_irq();
        t_emem();
        t_boot();
        summarize();
    end
endmodule // port_d_e_alt_function_override_tb

`default_nettype wire
